// >>> dv/tb_eeprom_program_erase_control.sv
// self-checking bench for the eeprom program and erase control
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
	fails++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_eeprom_program_erase_control;
	logic                core_clk;
	logic                rst;
	logic [15:0]         reg_addr;
	logic [7:0]          reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [7:0]          reg_rdata;
	logic                special_mode_pin;
	logic                secure_pin;
	logic                expand_req_pin;
	logic                bus_expand_en;
	logic [7:0]          arr_rdata;
	logic                high_voltage_on;
	eepc_pkg::eepc_op_e  arr_op;
	logic [15:0]         arr_addr;
	logic [7:0]          arr_data;
	logic                opt_cell_sel;
	logic                eprom_path_latch;
	logic                pump_clock_select;
	int                  fails;
	int                  checks_done;
	int                  cyc;
	logic [7:0]          q;
	logic                hv_large;
	localparam logic [15:0] CTL = eepc_pkg::PROG_CTRL_ADDR;
	localparam logic [15:0] GRD = eepc_pkg::GUARD_ADDR;
	localparam logic [15:0] OPT = eepc_pkg::OPT_CELL_ADDR;
	// guard value, target address and whether voltage may come on
	logic [4:0]  tg [10] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h02,
		5'h04, 5'h04, 5'h04, 5'h08, 5'h08};
	logic [15:0] ta [10] = '{16'hb61f, 16'hb620, 16'hb620, 16'hb65f,
		16'hb660, 16'hb660, 16'hb6df, 16'hb6e0, 16'hb7ff, 16'hb6df};
	logic        te [10] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
		1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [7:0]  ec [4] = '{8'h06, 8'h0e, 8'h16, 8'h1e};
	eepc_pkg::eepc_op_e eo [4] = '{eepc_pkg::OP_BULK, eepc_pkg::OP_ROW,
		eepc_pkg::OP_BYTE, eepc_pkg::OP_BYTE};

	// array model answers with a pattern derived from the address
	assign arr_rdata = reg_addr[7:0] ^ 8'ha5;

	eepc_top dut (
		.core_clk          (core_clk),
		.rst               (rst),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.special_mode_pin  (special_mode_pin),
		.secure_pin        (secure_pin),
		.expand_req_pin    (expand_req_pin),
		.bus_expand_en     (bus_expand_en),
		.array_base_field  (4'h0),
		.arr_rdata         (arr_rdata),
		.high_voltage_on   (high_voltage_on),
		.arr_op            (arr_op),
		.arr_addr          (arr_addr),
		.arr_data          (arr_data),
		.opt_cell_sel      (opt_cell_sel),
		.eprom_path_latch  (eprom_path_latch),
		.pump_clock_select (pump_clock_select)
	);

	// large array variant with base digit b; only its voltage is watched
	eepc_top #(.LARGE(1'b1)) dut_large (
		.core_clk          (core_clk),
		.rst               (rst),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (),
		.special_mode_pin  (special_mode_pin),
		.secure_pin        (secure_pin),
		.expand_req_pin    (expand_req_pin),
		.bus_expand_en     (),
		.array_base_field  (4'hb),
		.arr_rdata         (arr_rdata),
		.high_voltage_on   (hv_large),
		.arr_op            (),
		.arr_addr          (),
		.arr_data          (),
		.opt_cell_sel      (),
		.eprom_path_latch  (),
		.pump_clock_select ()
	);

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic cy(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cy

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// latch, write target, add voltage, check, then clear the control
	task automatic op(input logic [7:0] c, input logic [15:0] a,
		input logic ehv, input eepc_pkg::eepc_op_e eop);
		logic eopt;
		eopt = (a == OPT) && !(c[2] && !c[3] && !c[4]);
		wr(CTL, c);
		wr(a, 8'h5a);
		wr(CTL, c | 8'h01);
		cy(2);
		`CHK("hv", ehv, high_voltage_on)
		if (ehv) begin
			`CHK("op", eop, arr_op)
			`CHK("opt", eopt, opt_cell_sel)
		end
		wr(CTL, 8'h00);
		cy(2);
		`CHK("hv off", 1'b0, high_voltage_on)
		`CHK("op none", eepc_pkg::OP_NONE, arr_op)
	endtask : op

	task automatic t_reset();
		cy(1);
		`CHK("hv rst", 1'b0, high_voltage_on)
		`CHK("op rst", eepc_pkg::OP_NONE, arr_op)
		rd(GRD, q);
		`CHK("guard rst", 8'h1f, q)
		wr(GRD, 8'h00);
		rd(GRD, q);
		`CHK("guard clr", 8'h00, q)
	endtask : t_reset

	task automatic t_program();
		wr(CTL, 8'h02);
		rd(CTL, q);
		`CHK("ctrl lat", 8'h02, q)
		rd(16'hb610, q);
		`CHK("rd latched", 8'hff, q)
		wr(16'hb610, 8'h3c);
		wr(CTL, 8'h1b);
		cy(2);
		`CHK("hv on", 1'b1, high_voltage_on)
		`CHK("op prog", eepc_pkg::OP_PROG, arr_op)
		`CHK("tgt addr", 16'hb610, arr_addr)
		`CHK("tgt data", 8'h3c, arr_data)
		wr(CTL, 8'h00);
		cy(2);
		`CHK("hv clr", 1'b0, high_voltage_on)
		rd(16'hb600, q);
		`CHK("rd array", 8'ha5, q)
	endtask : t_program

	task automatic t_refuse();
		wr(CTL, 8'h03);
		rd(CTL, q);
		`CHK("lat hv", 8'h00, q)
		wr(CTL, 8'h01);
		rd(CTL, q);
		`CHK("hv only", 8'h00, q)
		wr(CTL, 8'h22);
		rd(CTL, q);
		`CHK("two lat", 8'h00, q)
		wr(CTL, 8'h20);
		rd(CTL, q);
		`CHK("eprom lat", 8'h20, q)
		`CHK("eprom pin", 1'b1, eprom_path_latch)
		wr(CTL, 8'h00);
	endtask : t_refuse

	// option cell rewrite: erase, program, then reset; guards reopened
	task automatic t_option();
		op(8'h06, OPT, 1'b1, eepc_pkg::OP_BULK);
		op(8'h16, OPT, 1'b1, eepc_pkg::OP_BYTE);
		op(8'h02, OPT, 1'b1, eepc_pkg::OP_PROG);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		cy(1);
		`CHK("hv rst2", 1'b0, high_voltage_on)
		rd(CTL, q);
		`CHK("ctrl rst2", 8'h00, q)
		rd(GRD, q);
		`CHK("guard rst2", 8'h1f, q)
		wr(GRD, 8'h00);
		rd(GRD, q);
		`CHK("guard clr2", 8'h00, q)
	endtask : t_option

	task automatic t_guards();
		cy(64);
		wr(GRD, 8'h01);
		wr(GRD, 8'h00);
		rd(GRD, q);
		`CHK("guard late", 8'h01, q)
		@(posedge core_clk);
		special_mode_pin <= 1'b1;
		cy(4);
		for (int i = 0; i < 10; i++) begin
			wr(GRD, {3'h0, tg[i]});
			op(8'h02, ta[i], te[i], eepc_pkg::OP_PROG);
		end
		wr(GRD, 8'h10);
		op(8'h02, OPT, 1'b0, eepc_pkg::OP_PROG);
		wr(GRD, 8'h01);
		op(8'h06, 16'hb7f0, 1'b0, eepc_pkg::OP_BULK);
		op(8'h06, OPT, 1'b0, eepc_pkg::OP_BULK);
		wr(GRD, 8'h00);
		rd(GRD, q);
		`CHK("guard spec", 8'h00, q)
	endtask : t_guards

	// quarter 2 guarded, quarter 1 open in the large array variant
	task automatic t_large();
		wr(GRD, 8'h04);
		for (int i = 0; i < 2; i++) begin
			wr(CTL, 8'h02);
			wr((i == 1) ? 16'hba00 : 16'hbc00, 8'h5a);
			wr(CTL, 8'h03);
			cy(2);
			`CHK("hv large", (i == 1), hv_large)
			`CHK("hv std", 1'b0, high_voltage_on)
			wr(CTL, 8'h00);
		end
	endtask : t_large

	task automatic t_misc();
		@(posedge core_clk);
		expand_req_pin <= 1'b1;
		cy(6);
		`CHK("expand", 1'b1, bus_expand_en)
		@(posedge core_clk);
		secure_pin <= 1'b1;
		cy(6);
		`CHK("secure", 1'b0, bus_expand_en)
		rd(16'hb600, q);
		`CHK("rd secure", 8'ha5, q)
		wr(eepc_pkg::SYS_OPT_ADDR, 8'h40);
		cy(2);
		`CHK("pump", 1'b1, pump_clock_select)
		rd(16'h1000, q);
		`CHK("unmapped", 8'h00, q)
	endtask : t_misc

	initial begin
		fails = 0;
		checks_done = 0;
		cyc = 0;
		rst = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		special_mode_pin = 1'b0;
		secure_pin = 1'b0;
		expand_req_pin = 1'b0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_program();
		t_refuse();
		for (int i = 0; i < 4; i++)
			op(ec[i], 16'hb640, 1'b1, eo[i]);
		t_option();
		t_guards();
		t_large();
		t_misc();
		report_and_stop();
	end
endmodule : tb_eeprom_program_erase_control

// >>> inc/eepc_dec_if.sv
// address decode request and answer between the control and the decoder
`timescale 1ns/10ps
interface eepc_dec_if;
	logic [15:0] addr;
	logic [3:0]  base;
	logic [4:0]  guard;
	logic        in_array;
	logic        in_opt;
	logic        blocked;
	modport requester (output addr, base, guard,
		input in_array, in_opt, blocked);
	modport decoder (input addr, base, guard,
		output in_array, in_opt, blocked);
endinterface : eepc_dec_if

// >>> inc/eepc_pkg.sv
// constants, field layout and operation codes for the eeprom program/erase control
package eepc_pkg;
	// register addresses on the cpu register port
	localparam logic [15:0] PROG_CTRL_ADDR = 16'h103b;
	localparam logic [15:0] GUARD_ADDR     = 16'h1035;
	localparam logic [15:0] SYS_OPT_ADDR   = 16'h1039;
	localparam logic [15:0] OPT_CELL_ADDR  = 16'h103f;
	// standard array layout and guarded regions
	localparam logic [15:0] STD_BASE       = 16'hb600;
	localparam logic [15:0] STD_END0       = 16'hb61f;
	localparam logic [15:0] STD_END1       = 16'hb65f;
	localparam logic [15:0] STD_END2       = 16'hb6df;
	localparam logic [15:0] STD_LAST       = 16'hb7ff;
	// large array: upper digit from base field, 512-byte quarters
	localparam int          LARGE_SEL_BIT  = 11;
	localparam int          QUARTER_HI     = 10;
	localparam int          QUARTER_LO     = 9;
	// program control register fields
	localparam int          HV_BIT         = 0;
	localparam int          LAT_BIT        = 1;
	localparam int          ERASE_BIT      = 2;
	localparam int          ROW_BIT        = 3;
	localparam int          BYTE_BIT       = 4;
	localparam int          EPL_BIT        = 5;
	// block guard register fields
	localparam int          OPT_GUARD_BIT  = 4;
	localparam logic [4:0]  GUARD_RESET    = 5'h1f;
	// system option register field
	localparam int          PUMP_SEL_BIT   = 6;
	localparam logic        PUMP_SEL_RESET = 1'b0;
	// outside special modes, guard bits may be cleared only inside this many cycles after reset
	localparam logic [6:0]  GUARD_WINDOW   = 7'h40;
	// read value of the array while it is latched for programming
	localparam logic [7:0]  READ_BLOCKED   = 8'hff;
	localparam logic [7:0]  READ_UNMAPPED  = 8'h00;

	typedef enum logic [4:0] {
		OP_NONE = 5'b00001,
		OP_PROG = 5'b00010,
		OP_BYTE = 5'b00100,
		OP_ROW  = 5'b01000,
		OP_BULK = 5'b10000
	} eepc_op_e;
endpackage : eepc_pkg

// >>> rtl/eepc_decode.sv
// address decoder: array hit, option cell hit and guard of the addressed block
`timescale 1ns/10ps
module eepc_decode #(
	parameter bit LARGE = 1'b0
) (
	// decode request and answer
	eepc_dec_if.decoder dec
);
	always_comb begin
		dec.in_array = 1'b0;
		dec.blocked  = 1'b0;
		dec.in_opt   = (dec.addr == eepc_pkg::OPT_CELL_ADDR);
		if (dec.in_opt) begin
			// option cells carry their own guard bit
			dec.blocked = dec.guard[eepc_pkg::OPT_GUARD_BIT];
		end else if (LARGE) begin
			// four 512-byte quarters above the base digit
			if (dec.addr[15:12] == dec.base &&
					dec.addr[eepc_pkg::LARGE_SEL_BIT]) begin
				dec.in_array = 1'b1;
				dec.blocked  = dec.guard[dec.addr[eepc_pkg::QUARTER_HI:
					eepc_pkg::QUARTER_LO]];
			end
		end else if (dec.addr >= eepc_pkg::STD_BASE &&
				dec.addr <= eepc_pkg::STD_LAST) begin
			dec.in_array = 1'b1;
			// 32, 64, 128 and 288 byte regions upward
			if (dec.addr <= eepc_pkg::STD_END0) begin
				dec.blocked = dec.guard[0];
			end else if (dec.addr <= eepc_pkg::STD_END1) begin
				dec.blocked = dec.guard[1];
			end else if (dec.addr <= eepc_pkg::STD_END2) begin
				dec.blocked = dec.guard[2];
			end else begin
				dec.blocked = dec.guard[3];
			end
		end
	end
endmodule : eepc_decode

// >>> rtl/eepc_top.sv
// eeprom program and erase control with block guard and option cell access
`timescale 1ns/10ps
module eepc_top #(
	parameter bit LARGE  = 1'b0,
	parameter bit SHARED = 1'b1
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// register port
	input  wire logic [15:0]       reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// mode and security pins
	input  wire logic              special_mode_pin,
	input  wire logic              secure_pin,
	input  wire logic              expand_req_pin,
	output logic                   bus_expand_en,
	// option cell field and array read data
	input  wire logic [3:0]        array_base_field,
	input  wire logic [7:0]        arr_rdata,
	// array control
	output logic                   high_voltage_on,
	output eepc_pkg::eepc_op_e     arr_op,
	output logic      [15:0]       arr_addr,
	output logic      [7:0]        arr_data,
	output logic                   opt_cell_sel,
	output logic                   eprom_path_latch,
	output logic                   pump_clock_select
);
	// synchronised pins
	logic       special_m;
	logic       special_s;
	logic       secure_m;
	logic       secure_s;
	logic       expand_m;
	logic       expand_s;
	// control register bits
	logic       high_voltage_enable;
	logic       nv_array_latch;
	logic       erase_sel;
	logic       row_sel;
	logic       byte_sel;
	logic       next_lat;
	logic       next_hv;
	logic       next_epl;
	// guard and window
	logic [4:0] block_guard_bits;
	logic [6:0] win_cnt;
	logic       window_open;
	// captured target
	logic [15:0] lat_addr;
	logic [7:0]  lat_data;
	logic        lat_valid;
	logic        lat_block;
	// bus decode
	logic        ctrl_wr;
	logic        array_wr;
	logic        array_hit;

	eepc_dec_if dec_bus ();
	eepc_dec_if dec_lat ();

	eepc_decode #(.LARGE(LARGE)) u_dec_bus (.dec(dec_bus));
	eepc_decode #(.LARGE(LARGE)) u_dec_lat (.dec(dec_lat));

	function automatic eepc_pkg::eepc_op_e decode_op(input logic er,
			input logic rw, input logic by);
		if (!er) begin
			decode_op = eepc_pkg::OP_PROG;
		end else if (by) begin
			decode_op = eepc_pkg::OP_BYTE;
		end else if (rw) begin
			decode_op = eepc_pkg::OP_ROW;
		end else begin
			decode_op = eepc_pkg::OP_BULK;
		end
	endfunction : decode_op

	assign dec_bus.addr  = reg_addr;
	assign dec_bus.base  = array_base_field;
	assign dec_bus.guard = block_guard_bits;
	assign dec_lat.addr  = lat_addr;
	assign dec_lat.base  = array_base_field;
	assign dec_lat.guard = block_guard_bits;

	assign ctrl_wr   = reg_wr && reg_addr == eepc_pkg::PROG_CTRL_ADDR;
	assign array_hit = dec_bus.in_array || dec_bus.in_opt;
	assign array_wr  = reg_wr && array_hit;
	assign window_open = win_cnt < eepc_pkg::GUARD_WINDOW;

	// two-stage pin synchronisers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			special_m <= 1'b0;
			special_s <= 1'b0;
			secure_m  <= 1'b0;
			secure_s  <= 1'b0;
			expand_m  <= 1'b0;
			expand_s  <= 1'b0;
		end else begin
			special_m <= special_mode_pin;
			special_s <= special_m;
			secure_m  <= secure_pin;
			secure_s  <= secure_m;
			expand_m  <= expand_req_pin;
			expand_s  <= expand_m;
		end
	end

	// expanded bus only when security is off
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_expand_en <= 1'b0;
		end else begin
			bus_expand_en <= expand_s && !secure_s;
		end
	end

	// cycles since reset release for the guard clear window
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			win_cnt <= '0;
		end else if (window_open) begin
			win_cnt <= win_cnt + 7'h01;
		end
	end

	// guard bits: free in special modes, else set-only after window
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			block_guard_bits <= eepc_pkg::GUARD_RESET;
		end else if (reg_wr && reg_addr == eepc_pkg::GUARD_ADDR) begin
			if (window_open || special_s) begin
				block_guard_bits <= reg_wdata[4:0];
			end else begin
				block_guard_bits <= block_guard_bits | reg_wdata[4:0];
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pump_clock_select <= eepc_pkg::PUMP_SEL_RESET;
		end else if (reg_wr && reg_addr == eepc_pkg::SYS_OPT_ADDR) begin
			pump_clock_select <= reg_wdata[eepc_pkg::PUMP_SEL_BIT];
		end
	end

	// next values of latch, voltage and eprom latch on a control write
	always_comb begin
		next_lat = reg_wdata[eepc_pkg::LAT_BIT];
		next_epl = SHARED ? reg_wdata[eepc_pkg::EPL_BIT] : 1'b0;
		// voltage only when its latch already stands
		next_hv  = reg_wdata[eepc_pkg::HV_BIT] &&
			(nv_array_latch || eprom_path_latch);
		// latch and voltage raised together: neither
		if (reg_wdata[eepc_pkg::HV_BIT] && !nv_array_latch &&
				reg_wdata[eepc_pkg::LAT_BIT]) begin
			next_lat = 1'b0;
		end
		if (reg_wdata[eepc_pkg::HV_BIT] && !eprom_path_latch &&
				next_epl) begin
			next_epl = 1'b0;
		end
		// eprom latch frozen while voltage is on
		if (high_voltage_enable) begin
			next_epl = eprom_path_latch;
		end
		// both latches requested: neither
		if (next_lat && next_epl) begin
			next_lat = 1'b0;
			next_epl = 1'b0;
		end
	end

	// control register at its fixed address
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			high_voltage_enable <= 1'b0;
			nv_array_latch      <= 1'b0;
			eprom_path_latch    <= 1'b0;
			erase_sel           <= 1'b0;
			row_sel             <= 1'b0;
			byte_sel            <= 1'b0;
		end else if (ctrl_wr) begin
			high_voltage_enable <= next_hv;
			nv_array_latch      <= next_lat;
			eprom_path_latch    <= next_epl;
			erase_sel           <= reg_wdata[eepc_pkg::ERASE_BIT];
			row_sel             <= reg_wdata[eepc_pkg::ROW_BIT];
			byte_sel            <= reg_wdata[eepc_pkg::BYTE_BIT];
		end
	end

	// capture target of array writes while latched, voltage off
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lat_addr  <= '0;
			lat_data  <= '0;
			lat_valid <= 1'b0;
		end else if (!nv_array_latch) begin
			lat_valid <= 1'b0;
		end else if (array_wr && !high_voltage_enable) begin
			lat_addr  <= reg_addr;
			lat_data  <= reg_wdata;
			lat_valid <= 1'b1;
		end
	end

	// guard of the captured target; bulk needs every array block open
	always_comb begin
		if (decode_op(erase_sel, row_sel, byte_sel) ==
				eepc_pkg::OP_BULK) begin
			lat_block = |block_guard_bits[3:0];
		end else begin
			lat_block = dec_lat.blocked;
		end
	end

	// drive the array: voltage only with latch, target and open guard
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			high_voltage_on <= 1'b0;
			arr_op          <= eepc_pkg::OP_NONE;
			arr_addr        <= '0;
			arr_data        <= '0;
			opt_cell_sel    <= 1'b0;
		end else begin
			high_voltage_on <= high_voltage_enable && nv_array_latch &&
				lat_valid && !lat_block;
			arr_op   <= nv_array_latch ?
				decode_op(erase_sel, row_sel, byte_sel) : eepc_pkg::OP_NONE;
			arr_addr <= lat_addr;
			arr_data <= lat_data;
			// bulk erase never reaches the option cells
			opt_cell_sel <= nv_array_latch && lat_valid && dec_lat.in_opt &&
				decode_op(erase_sel, row_sel, byte_sel) != eepc_pkg::OP_BULK;
		end
	end

	// read data one cycle after the strobe; security does not gate it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= eepc_pkg::READ_UNMAPPED;
		end else if (reg_rd) begin
			if (reg_addr == eepc_pkg::PROG_CTRL_ADDR) begin
				reg_rdata <= {2'b00, eprom_path_latch, byte_sel, row_sel,
					erase_sel, nv_array_latch, high_voltage_enable};
			end else if (reg_addr == eepc_pkg::GUARD_ADDR) begin
				reg_rdata <= {3'b000, block_guard_bits};
			end else if (reg_addr == eepc_pkg::SYS_OPT_ADDR) begin
				reg_rdata <= {1'b0, pump_clock_select, 6'h00};
			end else if (array_hit) begin
				// array hidden while latched
				reg_rdata <= nv_array_latch ? eepc_pkg::READ_BLOCKED
					: arr_rdata;
			end else begin
				reg_rdata <= eepc_pkg::READ_UNMAPPED;
			end
		end else begin
			reg_rdata <= eepc_pkg::READ_UNMAPPED;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_clear_write;
		ctrl_wr && reg_wdata == 8'h00;
	endsequence

	sequence s_voltage_gone;
		!high_voltage_enable && !nv_array_latch ##1 !high_voltage_on;
	endsequence

	a_clear_drops_voltage: assert property (
		s_clear_write |=> s_voltage_gone)
		else $error("clear write did not drop voltage and latch");

	a_no_voltage_unlatched: assert property (
		!nv_array_latch |=> !high_voltage_on)
		else $error("voltage on with latch clear");

	a_guard_blocks_voltage: assert property (
		lat_valid && lat_block |=> !high_voltage_on)
		else $error("voltage reached a guarded block");

	a_joint_set_refused: assert property (
		ctrl_wr && !nv_array_latch && !eprom_path_latch &&
		reg_wdata[1:0] == 2'b11
		|=> !nv_array_latch && !high_voltage_enable)
		else $error("latch and voltage set in one write");

	a_voltage_needs_latch: assert property (
		ctrl_wr && !nv_array_latch && !eprom_path_latch
		|=> !high_voltage_enable)
		else $error("voltage enabled without a standing latch");

	a_latches_exclusive: assert property (
		!(nv_array_latch && eprom_path_latch))
		else $error("both latches set");

	a_guard_set_only: assert property (
		!window_open && !special_s |=>
		(block_guard_bits | $past(block_guard_bits)) == block_guard_bits)
		else $error("guard bit cleared after the window");

	a_guard_reset_set: assert property (
		$fell(rst) |-> block_guard_bits == eepc_pkg::GUARD_RESET)
		else $error("guard bits not set out of reset");

	a_read_hidden: assert property (
		reg_rd && array_hit && nv_array_latch
		|=> reg_rdata == eepc_pkg::READ_BLOCKED)
		else $error("array readable while latched");

	a_capture_write: assert property (
		array_wr && nv_array_latch && !high_voltage_enable
		|=> lat_valid && lat_addr == $past(reg_addr))
		else $error("latched write not captured");

	a_program_scope: assert property (
		nv_array_latch && !erase_sel |=> arr_op == eepc_pkg::OP_PROG)
		else $error("program took an erase scope");

	a_byte_over_row: assert property (
		nv_array_latch && erase_sel && byte_sel
		|=> arr_op == eepc_pkg::OP_BYTE)
		else $error("byte bit did not override row bit");

	a_bulk_spares_option: assert property (
		erase_sel && !row_sel && !byte_sel |=> !opt_cell_sel)
		else $error("bulk erase reached the option cells");

	a_secure_single_chip: assert property (
		secure_s |=> !bus_expand_en)
		else $error("expanded bus visible under security");
endmodule : eepc_top
